/* File: inc/wdt_pkg.sv */
// watchdog package: control bit positions, mode codes, counts
// assumes the low-speed oscillator tick is delivered as a one-cycle pulse
package wdt_pkg;
    localparam logic [3:0] WDT_CFG_GP       = 4'h_F;
    localparam logic [3:0] WDT_CFG_STOP_LP  = 4'h_5;
    localparam int         WDT_GRACE_CLKS   = 512;
    localparam int         WDT_TIMEOUT_CNT  = 64;
    localparam int         WDT_PRESC_W      = 8;
    localparam int         WDT_CNT_W        = 6;
    localparam int         WDT_GRACE_W      = 10;
    localparam int         BIT_RUN          = 7;
    localparam int         BIT_CLR          = 6;
    localparam int         BIT_FLAG         = 5;
    localparam int         BIT_IDLE_RUN     = 4;
    localparam int         BIT_RST_FLAG     = 3;
    localparam int         BIT_PS_HI        = 2;
    localparam logic [2:0] PS_RESET         = 3'h_7;
    localparam logic [7:0] TA_KEY1          = 8'h_AA;
    localparam logic [7:0] TA_KEY2          = 8'h_55;
    typedef enum logic [1:0]
    {
        TA_IDLE = 2'b00,
        TA_HALF = 2'b01,
        TA_OPEN = 2'b10
    } wdt_ta_t;
endpackage : wdt_pkg

/* File: rtl/wdt_divider.sv */
// prescaler for the watchdog: picks a power-of-two tap per prescale code
// assumes osc_tick is a single-cycle pulse at the oscillator rate
`timescale 1ns/1ps
module wdt_divider
    import wdt_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    input  wire logic             clear,
    input  wire logic             osc_tick,
    input  wire logic [2:0]       prescale,
    output logic                  div_tick
);
    logic [WDT_PRESC_W-1:0] count;
    logic [WDT_PRESC_W-1:0] mask;
    wire                    tap_hit;

    // codes 0..7 divide by 1,4,8,16,32,64,128,256
    always_comb
    begin
        mask = '0;
        if (prescale != 3'h_0)
            // four-bit sum: code 7 must not wrap to a shift of zero
            mask = WDT_PRESC_W'((1 << ({1'b0, prescale} + 4'h_1)) - 1);
    end

    assign tap_hit = ((count & mask) == mask);

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            count <= '0;
        else if (clear)
            count <= '0;
        else if (osc_tick)
            count <= tap_hit ? '0 : count + 1'b1;
    end

    assign div_tick = osc_tick && tap_hit && !clear;
endmodule : wdt_divider

/* File: rtl/wdt_timer.sv */
// watchdog: time-out reset timer or general-purpose long timer
// assumes control writes arrive as a strobe with byte; power-on reset separate
`timescale 1ns/1ps
// Functional notes
// - config not all ones selects time-out reset mode
// - reset mode runs in low power unless config equals 5
// - run and idle-run bits ignored in reset mode
// - reset mode counts from start of execution without software
// - three-bit prescale field in low control bits picks interval
// - elapsed interval sets the time-out flag
// - interrupt requested when flag, own enable and global enable set
// - 512 oscillator clocks after time-out without clear cause reset
// - writing clear bit clears counter; bit self-clears when done
// - watchdog reset sets flag; only power-on clears; software may clear
// - counter and prescaler cleared on low-power entry, wake and reset
// - config all ones gives general-purpose timer with run bits
// - general mode: run bit starts and halts counting
// - general mode sets flag each interval, keeps counting, no reset
// - counts from slow oscillator in power-down; time-out wakes cpu
// - interval is 64 prescaled periods; dividers 1,4,8..256
// - general mode idle-run bit chooses counting in low power
module wdt_timer
    import wdt_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       por_n,
    input  wire logic [7:0] nonvolatile_config_byte,
    input  wire logic       cpu_running,
    input  wire logic       low_power,
    input  wire logic       osc_tick,
    input  wire logic       global_irq_enable,
    input  wire logic       watchdog_irq_enable,
    input  wire logic       ta_write,
    input  wire logic [7:0] ta_data,
    input  wire logic       ctrl_write,
    input  wire logic [7:0] ctrl_data,
    output logic [7:0]      watchdog_control,
    output logic            watchdog_irq,
    output logic            wake_cpu,
    output logic            watchdog_reset
);
    wdt_ta_t                ta_state;
    wdt_ta_t                next_ta_state;
    logic                   watchdog_run;
    logic                   watchdog_idle_run;
    logic                   watchdog_counter_clear;
    logic                   watchdog_timeout_flag;
    logic                   watchdog_reset_flag;
    logic [2:0]             watchdog_prescale;
    logic [WDT_CNT_W-1:0]   count;
    logic [WDT_GRACE_W-1:0] grace;
    logic                   grace_on;
    logic                   low_power_q;
    logic                   div_tick;

    wire [3:0] watchdog_mode_config = nonvolatile_config_byte[7:4];
    wire gp_mode     = (watchdog_mode_config == WDT_CFG_GP);
    wire lp_edge     = low_power ^ low_power_q;
    wire lp_allowed  = gp_mode ? watchdog_idle_run
                               : (watchdog_mode_config != WDT_CFG_STOP_LP);
    wire run_enable  = gp_mode ? watchdog_run : cpu_running;
    wire counting    = run_enable && (!low_power || lp_allowed);
    wire wr_ok       = ctrl_write && (ta_state == TA_OPEN);
    wire clr_req     = wr_ok && ctrl_data[BIT_CLR];
    wire flush       = lp_edge || watchdog_counter_clear || !counting;
    wire cnt_tick    = div_tick && counting;
    wire timeout     = cnt_tick && (count == WDT_CNT_W'(WDT_TIMEOUT_CNT - 1));
    wire grace_done  = grace_on && osc_tick && !gp_mode
                       && (grace == WDT_GRACE_W'(WDT_GRACE_CLKS - 1));

    wdt_divider u_div
    (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .clear    (flush),
        .osc_tick (osc_tick),
        .prescale (watchdog_prescale),
        .div_tick (div_tick)
    );

    // unlock sequence: AA then 55, opens one following write
    always_comb
    begin
        next_ta_state = TA_IDLE;
        unique case (ta_state)
            TA_IDLE: next_ta_state = (ta_write && ta_data == TA_KEY1) ? TA_HALF : TA_IDLE;
            TA_HALF: next_ta_state = (ta_write && ta_data == TA_KEY2) ? TA_OPEN : TA_IDLE;
            TA_OPEN: next_ta_state = ctrl_write ? TA_IDLE : TA_OPEN;
            default: next_ta_state = TA_IDLE;
        endcase
        if (ta_state != TA_IDLE && ta_write && !(ta_state == TA_HALF && ta_data == TA_KEY2))
            next_ta_state = (ta_data == TA_KEY1) ? TA_HALF : TA_IDLE;
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            ta_state <= TA_IDLE;
        else
            ta_state <= next_ta_state;
    end

    // count and grace window; reset_n clears them, por_n does not
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count       <= '0;
            grace       <= '0;
            grace_on    <= 1'b0;
            low_power_q <= 1'b0;
        end
        else
        begin
            low_power_q <= low_power;
            if (flush)
                count <= '0;
            else if (cnt_tick)
                count <= count + 1'b1;
            if (flush || gp_mode)
            begin
                grace    <= '0;
                grace_on <= 1'b0;
            end
            // later time-outs must not restart a running window
            else if (timeout && !grace_on)
            begin
                grace    <= '0;
                grace_on <= 1'b1;
            end
            else if (grace_on && osc_tick)
                grace <= grace + 1'b1;
        end
    end

    // control bits; software fields follow the unlocked write
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            watchdog_run           <= 1'b0;
            watchdog_idle_run      <= 1'b0;
            watchdog_counter_clear <= 1'b0;
            watchdog_timeout_flag  <= 1'b0;
        end
        else
        begin
            if (wr_ok)
            begin
                watchdog_run      <= ctrl_data[BIT_RUN];
                watchdog_idle_run <= ctrl_data[BIT_IDLE_RUN];
            end
            // clear completes in one cycle; then the bit reads back zero
            watchdog_counter_clear <= clr_req;
            if (timeout)
                watchdog_timeout_flag <= 1'b1;
            else if (wr_ok)
                watchdog_timeout_flag <= ctrl_data[BIT_FLAG];
        end
    end

    // only power-on reset initialises these two (flag to 0, prescale to 7); reset_n does not
    always_ff @(posedge ref_clk or negedge por_n)
    begin
        if (!por_n)
        begin
            watchdog_reset_flag <= 1'b0;
            watchdog_prescale   <= PS_RESET;
        end
        else
        begin
            if (grace_done)
                watchdog_reset_flag <= 1'b1;
            else if (wr_ok)
                watchdog_reset_flag <= ctrl_data[BIT_RST_FLAG];
            if (wr_ok)
                watchdog_prescale <= ctrl_data[BIT_PS_HI:0];
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            watchdog_control <= '0;
            watchdog_irq     <= 1'b0;
            wake_cpu         <= 1'b0;
            watchdog_reset   <= 1'b0;
        end
        else
        begin
            watchdog_control <= {watchdog_run, watchdog_counter_clear | clr_req,
                                 watchdog_timeout_flag, watchdog_idle_run,
                                 watchdog_reset_flag, watchdog_prescale};
            watchdog_irq     <= watchdog_timeout_flag && watchdog_irq_enable
                                && global_irq_enable;
            wake_cpu         <= timeout && low_power;
            watchdog_reset   <= grace_done;
        end
    end
endmodule : wdt_timer

/* File: verification/wdt_timer_asserts.sv */
// checker for wdt_timer port timing: irq, wake, reset pulse, locked writes
// assumes bind onto wdt_timer, single clock domain
`timescale 1ns/1ps
module wdt_chk
    import wdt_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       reset_n,
    input wire logic [7:0] nonvolatile_config_byte,
    input wire logic       global_irq_enable,
    input wire logic       watchdog_irq_enable,
    input wire logic       ta_write,
    input wire logic [7:0] ta_data,
    input wire logic       ctrl_write,
    input wire logic       low_power,
    input wire logic [7:0] watchdog_control,
    input wire logic       watchdog_irq,
    input wire logic       wake_cpu,
    input wire logic       watchdog_reset
);
    wdt_ta_t ta_st;
    wdt_ta_t next_ta_st;
    wire     ok_wr = ctrl_write && (ta_st == TA_OPEN);
    // a stray key byte, or a gap between the keys, drops the unlock
    assign next_ta_st = !ta_write
        ? ((ta_st == TA_OPEN && !ctrl_write) ? TA_OPEN : TA_IDLE) :
        (ta_data == TA_KEY1) ? TA_HALF :
        (ta_data == TA_KEY2 && ta_st == TA_HALF) ? TA_OPEN : TA_IDLE;
    always_ff @(posedge ref_clk or negedge reset_n)
        if (!reset_n)
            ta_st <= TA_IDLE;
        else
            ta_st <= next_ta_st;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    property p_irq; watchdog_irq == (watchdog_control[BIT_FLAG] && $past(global_irq_enable)
        && $past(watchdog_irq_enable)); endproperty
    a_irq: assert property (p_irq) else $error("irq differs from flag and enables");
    // a reset also clears the flag; that fall is not a write
    property p_wr; reset_n && ($changed(watchdog_control[BIT_IDLE_RUN])
        || $fell(watchdog_control[BIT_FLAG])) |-> $past(ok_wr, 2); endproperty
    a_wr: assert property (p_wr) else $error("control bit moved without unlocked write");
    property p_clr; $rose(watchdog_control[BIT_CLR]) |-> ##[1:2] !watchdog_control[BIT_CLR];
    endproperty
    a_clr: assert property (p_clr) else $error("clear bit did not self clear");
    property p_wake; wake_cpu |-> $past(low_power) ##1 !wake_cpu; endproperty
    a_wake: assert property (p_wake) else $error("bad wake pulse");
    property p_wflag; wake_cpu |-> ##[0:1] watchdog_control[BIT_FLAG]; endproperty
    a_wflag: assert property (p_wflag) else $error("wake without flag");
    property p_gp; watchdog_reset |-> $past(nonvolatile_config_byte[7:4]) != WDT_CFG_GP; endproperty
    a_gp: assert property (p_gp) else $error("reset in general mode");
    property p_rflag; watchdog_reset |=> watchdog_control[BIT_RST_FLAG]; endproperty
    a_rflag: assert property (p_rflag) else $error("reset without reset flag");
    property p_rpulse; watchdog_reset |=> !watchdog_reset; endproperty
    a_rpulse: assert property (p_rpulse) else $error("reset pulse too long");
endmodule : wdt_chk

bind wdt_timer wdt_chk u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
    .nonvolatile_config_byte(nonvolatile_config_byte), .global_irq_enable(global_irq_enable),
    .watchdog_irq_enable(watchdog_irq_enable), .ta_write(ta_write), .ta_data(ta_data),
    .ctrl_write(ctrl_write), .low_power(low_power), .watchdog_control(watchdog_control),
    .watchdog_irq(watchdog_irq), .wake_cpu(wake_cpu), .watchdog_reset(watchdog_reset));

/* File: verification/tb.sv */
// self-checking bench for wdt_timer: locked writes, both modes, time-outs
// assumes osc_tick every second clock so time-outs stay short
`timescale 1ns/1ps
module tb;
    import wdt_pkg::*;
    logic       ref_clk = 0, reset_n = 0, por_n = 0, cpu_running = 0, low_power = 0;
    logic       osc_tick = 0, global_irq_enable = 0, watchdog_irq_enable = 0;
    logic       ta_write = 0, ctrl_write = 0, watchdog_irq, wake_cpu, watchdog_reset;
    logic [7:0] nonvolatile_config_byte = 8'h_F0, ta_data = 8'h_00, ctrl_data = 8'h_00;
    logic [7:0] watchdog_control;
    int         err_count = 0, total_checks = 0, n, i;
    wdt_timer dut (.ref_clk(ref_clk), .reset_n(reset_n), .por_n(por_n),
        .nonvolatile_config_byte(nonvolatile_config_byte), .cpu_running(cpu_running),
        .low_power(low_power), .osc_tick(osc_tick), .global_irq_enable(global_irq_enable),
        .watchdog_irq_enable(watchdog_irq_enable), .ta_write(ta_write), .ta_data(ta_data),
        .ctrl_write(ctrl_write), .ctrl_data(ctrl_data), .watchdog_control(watchdog_control),
        .watchdog_irq(watchdog_irq), .wake_cpu(wake_cpu), .watchdog_reset(watchdog_reset));
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) osc_tick <= ~osc_tick;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic near(input int v, input int e, input int tol);
        chk(8'(v >= e - tol && v <= e + tol), 8'h_01);
    endtask : near
    task automatic ta(input logic [7:0] d);
        @(posedge ref_clk);
        ta_write <= 1'b1;
        ta_data  <= d;
        @(posedge ref_clk);
        ta_write <= 1'b0;
    endtask : ta
    task automatic wr(input logic [7:0] d, input bit lock);
        // keys on back-to-back edges; an idle cycle between them drops the unlock
        if (!lock)
        begin
            @(posedge ref_clk);
            ta_write <= 1'b1;
            ta_data  <= TA_KEY1;
            @(posedge ref_clk);
            ta_data  <= TA_KEY2;
        end
        @(posedge ref_clk);
        ta_write   <= 1'b0;
        ctrl_write <= 1'b1;
        ctrl_data  <= d;
        @(posedge ref_clk);
        ctrl_write <= 1'b0;
        repeat (3) @(negedge ref_clk);
    endtask : wr
    // sel 0 flag, 1 system reset pulse, 2 wake pulse
    task automatic wait_for(input int sel, input int lim, output int k);
        k = 0;
        while (k < lim && (sel == 0 ? watchdog_control[BIT_FLAG] : sel == 1 ? watchdog_reset
            : wake_cpu) !== 1'b1)
        begin
            @(negedge ref_clk);
            k++;
        end
        if (k >= lim)
        begin
            err_count++;
            close_out();
        end
    endtask : wait_for
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out
    initial
    begin
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        por_n   <= 1'b1;
        repeat (2) @(negedge ref_clk);
        chk(watchdog_control, 8'h_07);
        wr(8'h_10, 1);
        chk(watchdog_control, 8'h_07);
        ta(TA_KEY2);
        ta(TA_KEY1);
        wr(8'h_10, 1);
        chk(watchdog_control, 8'h_07);
        wr(8'h_C0, 0);
        wait_for(0, 400, n);
        near(n, 127, 8);
        wr(8'h_80, 0);
        chk(watchdog_control, 8'h_80);
        // count keeps running while flag is cleared
        wait_for(0, 400, n);
        near(n, 122, 2);
        wr(8'h_40, 0);
        repeat (300) @(negedge ref_clk);
        chk(watchdog_control, 8'h_00);
        wr(8'h_C0, 0);
        @(posedge ref_clk) low_power <= 1'b1;
        repeat (300) @(negedge ref_clk);
        chk(watchdog_control, 8'h_80);
        @(posedge ref_clk) low_power <= 1'b0;
        wr(8'h_D0, 0);
        @(posedge ref_clk) low_power <= 1'b1;
        wait_for(2, 300, n);
        chk(8'(wake_cpu), 8'h_01);
        @(posedge ref_clk) low_power <= 1'b0;
        for (i = 1; i < 8; i++)
        begin
            wr(8'h_C0 | 8'(i), 0);
            wait_for(0, 40000, n);
            near(n, 256 << i, (4 << i) + 8);
        end
        @(posedge ref_clk) nonvolatile_config_byte <= 8'h_00;
        reset_n <= 1'b0;
        por_n   <= 1'b0;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        por_n   <= 1'b1;
        global_irq_enable   <= 1'b1;
        watchdog_irq_enable <= 1'b1;
        wr(8'h_00, 0);
        @(posedge ref_clk) cpu_running <= 1'b1;
        wait_for(0, 400, n);
        near(n, 128, 8);
        chk(8'(watchdog_irq), 8'h_01);
        @(posedge ref_clk) watchdog_irq_enable <= 1'b0;
        repeat (2) @(negedge ref_clk);
        chk(8'(watchdog_irq), 8'h_00);
        wr(8'h_40, 0);
        wait_for(1, 2000, n);
        near(n, 1152, 16);
        // give the checker time to see the reset flag before the reset lands
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b0;
        @(posedge ref_clk) reset_n <= 1'b1;
        repeat (2) @(negedge ref_clk);
        chk(watchdog_control & 8'h_0F, 8'h_08);
        wr(8'h_00, 0);
        chk(watchdog_control & 8'h_0F, 8'h_00);
        wr(8'h_40, 0);
        @(posedge ref_clk);
        nonvolatile_config_byte <= 8'h_50;
        low_power               <= 1'b1;
        repeat (300) @(negedge ref_clk);
        chk(watchdog_control & 8'h_20, 8'h_00);
        @(posedge ref_clk) nonvolatile_config_byte <= 8'h_00;
        wait_for(2, 300, n);
        chk(8'(wake_cpu), 8'h_01);
        close_out();
    end
endmodule : tb
